// File: core/kbchm_clock_ram.v
`timescale 1ns/1ps
`include "kbchm_defs.vh"

// clock ram banks, one synchronous write port, async read
module kbchm_clock_ram (
  input  wire                        mclk,
  input  wire                        wr_en,
  input  wire                        bank,
  input  wire [`KBCHM_RAM_AW-1:0]    addr,
  input  wire [`KBCHM_DW-1:0]        wr_data,
  output wire [`KBCHM_DW-1:0]        rd_data
);

  reg [`KBCHM_DW-1:0] mem_ff [0:`KBCHM_BANKS*`KBCHM_RAM_DEPTH-1];

  // write into selected location, contents survive reset
  always @(posedge mclk) begin
    if (wr_en) begin
      mem_ff[{bank, addr}] <= wr_data;
    end
  end

  assign rd_data = mem_ff[{bank, addr}];

endmodule // kbchm_clock_ram

// File: core/kbchm_host_port.v
`timescale 1ns/1ps
`include "kbchm_defs.vh"

// How it works
// [RL1] host write to data port loads input buffer, clears command flag, sets input full
// [RL2] host write to command port loads input buffer, sets command flag and input full
// [RL3] host reads status at command port, output buffer at data port
// [RL4] with gating, host data read clears output full and keyboard interrupt
// [RL5] all ports decode only when address enable shows a non-dma cycle
// [RL6] write to clock index port latches the clock ram location
// [RL7] clock data port reads or writes the location the index selects
// [RL8] cpu write of output register loads output buffer, sets output full
// [RL9] command flag sits in status bit three, copied from address line two
// [RL10] gated: keyboard interrupt follows output full when its port bit is one
// [RL11] keyboard interrupt is zero after reset
// [RL12] ungated: keyboard interrupt follows its port bit directly
// [RL13] gated with port bit one: mouse interrupt is inverted input full
// [RL14] ungated: mouse interrupt follows its port bit directly
// [RL15] a20 port bit drives its general pin when selected
// [RL16] keyboard reset port bit drives its pin, may also reset watchdog
// [RL17] bank zero at fixed index port, other bank at relocatable base
// [RL18] cpu read of input register clears input full and its interrupt
// [RL19] status clears on reset, host reads it, cpu writes it
// [RL20] other status bits are cpu-written user bits seen by host
// [RL21] host writes only when input full is clear, reads after output full
module kbchm_host_port (
  input  wire                  mclk,
  input  wire                  rst,
  // isa side, pins
  input  wire [9:0]            isa_sa,
  input  wire                  isa_aen,
  input  wire                  isa_iow_n,
  input  wire                  isa_ior_n,
  input  wire [`KBCHM_DW-1:0]  isa_data_in,
  output wire [`KBCHM_DW-1:0]  isa_data_out,
  output wire                  isa_data_oe_n,
  output wire                  host_out_irq,
  output wire                  host_in_irq,
  // internal cpu side, same clock
  input  wire                  cpu_out_wr,
  input  wire [`KBCHM_DW-1:0]  cpu_out_data,
  input  wire                  cpu_in_rd,
  output wire [`KBCHM_DW-1:0]  cpu_in_data,
  output wire                  cpu_in_irq,
  input  wire                  cpu_status_wr,
  input  wire [`KBCHM_DW-1:0]  cpu_status_data,
  output wire [`KBCHM_DW-1:0]  cpu_status,
  input  wire                  enable_flags,
  input  wire                  out_irq_port_bit,
  input  wire                  in_irq_port_bit,
  input  wire                  a20_port_bit,
  input  wire                  kb_reset_port_bit,
  // configuration
  input  wire                  a20_pin_sel,
  input  wire                  kb_reset_pin_sel,
  input  wire                  kb_reset_wdt_en,
  input  wire [`KBCHM_DW-1:0]  clock_mode,
  input  wire [9:0]            clock_sec_base,
  // general purpose pins and watchdog
  output wire                  a20_output_pin,
  output wire                  a20_output_oe_n,
  output wire                  kb_reset_output_pin,
  output wire                  kb_reset_output_oe_n,
  output wire                  wdt_reset
);

  // pin synchronisers
  reg  [9:0]            sa_s1_ff;
  reg  [9:0]            sa_s2_ff;
  reg  [`KBCHM_DW-1:0]  din_s1_ff;
  reg  [`KBCHM_DW-1:0]  din_s2_ff;
  reg                   aen_s1_ff;
  reg                   aen_s2_ff;
  reg                   iow_s1_ff;
  reg                   iow_s2_ff;
  reg                   ior_s1_ff;
  reg                   ior_s2_ff;
  reg                   iow_d_ff;
  reg                   ior_d_ff;

  // port state
  reg  [`KBCHM_DW-1:0]  in_buf_ff;
  reg  [`KBCHM_DW-1:0]  nxt_in_buf;
  reg  [`KBCHM_DW-1:0]  out_buf_ff;
  reg  [`KBCHM_DW-1:0]  nxt_out_buf;
  reg  [`KBCHM_DW-1:0]  status_ff;
  reg  [`KBCHM_DW-1:0]  nxt_status;
  reg  [`KBCHM_DW-1:0]  clk_idx_ff;
  reg                   clk_bank_ff;
  reg                   nxt_clk_bank;
  reg  [`KBCHM_DW-1:0]  nxt_clk_idx;
  reg  [`KBCHM_DW-1:0]  rd_data_ff;
  reg  [`KBCHM_DW-1:0]  nxt_rd_data;
  reg                   out_irq_ff;
  reg                   in_irq_ff;
  reg                   nxt_out_irq;
  reg                   nxt_in_irq;

  wire                  io_valid;
  wire                  wr_pulse;
  wire                  rd_pulse;
  wire                  hit_data;
  wire                  hit_cmd;
  wire                  hit_idx0;
  wire                  hit_dat0;
  wire                  hit_idx1;
  wire                  hit_dat1;
  wire                  bank1_en;
  wire                  ram_wr;
  wire [`KBCHM_DW-1:0]  ram_rd;
  wire                  any_hit;

  // address pins, two flip-flops
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sa_s1_ff <= `KBCHM_ADDR_ZERO;
      sa_s2_ff <= `KBCHM_ADDR_ZERO;
    end else begin
      sa_s1_ff <= isa_sa;
      sa_s2_ff <= sa_s1_ff;
    end
  end

  // write data pins, same latency as the strobes
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      din_s1_ff <= `KBCHM_BYTE_ZERO;
      din_s2_ff <= `KBCHM_BYTE_ZERO;
    end else begin
      din_s1_ff <= isa_data_in;
      din_s2_ff <= din_s1_ff;
    end
  end

  // address enable, resets to the dma level so nothing decodes
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      aen_s1_ff <= 1'b1;
      aen_s2_ff <= 1'b1;
    end else begin
      aen_s1_ff <= isa_aen;
      aen_s2_ff <= aen_s1_ff;
    end
  end

  // write strobe plus edge stage, idle high so reset makes no false edge
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      iow_s1_ff <= 1'b1;
      iow_s2_ff <= 1'b1;
      iow_d_ff  <= 1'b1;
    end else begin
      iow_s1_ff <= isa_iow_n;
      iow_s2_ff <= iow_s1_ff;
      iow_d_ff  <= iow_s2_ff;
    end
  end

  // read strobe plus edge stage, same shape
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ior_s1_ff <= 1'b1;
      ior_s2_ff <= 1'b1;
      ior_d_ff  <= 1'b1;
    end else begin
      ior_s1_ff <= isa_ior_n;
      ior_s2_ff <= ior_s1_ff;
      ior_d_ff  <= ior_s2_ff;
    end
  end

  // address decode, qualified by address enable low
  assign io_valid = ~aen_s2_ff;                                    // see [RL5]
  assign wr_pulse = iow_d_ff & ~iow_s2_ff;
  assign rd_pulse = ~ior_d_ff & ior_s2_ff;
  assign bank1_en = clock_mode[`KBCHM_MODE_BANK_EN];
  assign hit_data = io_valid & (sa_s2_ff == `KBCHM_ADDR_DATA);     // see [RL5]
  assign hit_cmd  = io_valid & (sa_s2_ff == `KBCHM_ADDR_CMD);      // see [RL5]
  assign hit_idx0 = io_valid & (sa_s2_ff == `KBCHM_ADDR_CLK_IDX);  // see [RL17]
  assign hit_dat0 = io_valid & (sa_s2_ff == `KBCHM_ADDR_CLK_DATA);
  // relocatable bank: index at base, data at base with address bit zero set
  assign hit_idx1 = io_valid & bank1_en
                  & (sa_s2_ff == clock_sec_base);                  // see [RL17]
  assign hit_dat1 = io_valid & bank1_en
                  & (sa_s2_ff == (clock_sec_base | `KBCHM_SEC_DATA_OFS)); // see [RL17]
  assign any_hit  = hit_data | hit_cmd | hit_idx0 | hit_dat0 | hit_idx1 | hit_dat1;

  // input buffer and status update
  always @* begin
    nxt_in_buf  = in_buf_ff;
    nxt_out_buf = out_buf_ff;
    nxt_status  = status_ff;
    if (cpu_status_wr) begin
      nxt_status = (status_ff & ~`KBCHM_ST_UD_MASK)
                 | (cpu_status_data & `KBCHM_ST_UD_MASK);          // see [RL19] [RL20]
    end
    if (cpu_in_rd) begin
      nxt_status[`KBCHM_ST_IN_FULL] = 1'b0;                        // see [RL18]
    end
    if (enable_flags & rd_pulse & hit_data) begin
      nxt_status[`KBCHM_ST_OUT_FULL] = 1'b0;                       // see [RL4]
    end
    if (cpu_out_wr) begin
      nxt_out_buf                    = cpu_out_data;               // see [RL8]
      nxt_status[`KBCHM_ST_OUT_FULL] = 1'b1;                       // see [RL8]
    end
    if (wr_pulse & (hit_data | hit_cmd)) begin
      nxt_in_buf                    = din_s2_ff;                   // see [RL1] [RL2]
      nxt_status[`KBCHM_ST_CD]      = sa_s2_ff[`KBCHM_SA_CD];      // see [RL9] [RL1] [RL2]
      nxt_status[`KBCHM_ST_IN_FULL] = 1'b1;                        // see [RL1] [RL2]
    end
  end

  // clock index latch and ram write
  always @* begin
    nxt_clk_idx  = clk_idx_ff;
    nxt_clk_bank = clk_bank_ff;
    if (wr_pulse & hit_idx0) begin
      nxt_clk_idx  = din_s2_ff;                                    // see [RL6]
      nxt_clk_bank = 1'b0;
    end else if (wr_pulse & hit_idx1) begin
      nxt_clk_idx  = din_s2_ff;                                    // see [RL6]
      nxt_clk_bank = 1'b1;
    end
  end

  assign ram_wr = wr_pulse & (hit_dat0 | hit_dat1);                // see [RL7]

  kbchm_clock_ram u_ram (
    .mclk    (mclk),
    .wr_en   (ram_wr),
    .bank    (clk_bank_ff),
    .addr    (clk_idx_ff[`KBCHM_RAM_AW-1:0]),
    .wr_data (din_s2_ff),
    .rd_data (ram_rd)
  );

  // read data mux, captured while read strobe is low
  always @* begin
    nxt_rd_data = rd_data_ff;
    if (~ior_s2_ff) begin
      if (hit_cmd) begin
        nxt_rd_data = status_ff;                                   // see [RL3]
      end else if (hit_data) begin
        nxt_rd_data = out_buf_ff;                                  // see [RL3]
      end else if (hit_idx0 | hit_idx1) begin
        nxt_rd_data = clk_idx_ff;
      end else if (hit_dat0 | hit_dat1) begin
        nxt_rd_data = ram_rd;                                      // see [RL7]
      end
    end
  end

  // keyboard interrupt, gated by output full or port driven
  always @* begin
    if (enable_flags) begin
      nxt_out_irq = out_irq_port_bit & nxt_status[`KBCHM_ST_OUT_FULL]; // see [RL10] [RL4]
    end else begin
      nxt_out_irq = out_irq_port_bit;                                  // see [RL12]
    end
  end

  // mouse interrupt, inverted input full when gated, else port driven
  always @* begin
    if (enable_flags) begin
      nxt_in_irq = in_irq_port_bit & ~nxt_status[`KBCHM_ST_IN_FULL];   // see [RL13]
    end else begin
      nxt_in_irq = in_irq_port_bit;                                    // see [RL14]
    end
  end

  // host to cpu byte
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      in_buf_ff <= `KBCHM_BYTE_ZERO;
    end else begin
      in_buf_ff <= nxt_in_buf;
    end
  end

  // cpu to host byte
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_buf_ff <= `KBCHM_BYTE_ZERO;
    end else begin
      out_buf_ff <= nxt_out_buf;
    end
  end

  // status register, cleared by reset
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_ff <= `KBCHM_ST_RESET;                                // see [RL19]
    end else begin
      status_ff <= nxt_status;
    end
  end

  // clock ram index and bank
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      clk_idx_ff  <= `KBCHM_IDX_RESET;
      clk_bank_ff <= 1'b0;
    end else begin
      clk_idx_ff  <= nxt_clk_idx;
      clk_bank_ff <= nxt_clk_bank;
    end
  end

  // read data held for the bus
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data_ff <= `KBCHM_BYTE_ZERO;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // interrupt outputs, low out of reset
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_irq_ff <= 1'b0;                                          // see [RL11]
      in_irq_ff  <= 1'b0;
    end else begin
      out_irq_ff <= nxt_out_irq;
      in_irq_ff  <= nxt_in_irq;
    end
  end

  // bus drive only during a decoded read
  assign isa_data_out  = rd_data_ff;
  assign isa_data_oe_n = ~(~ior_s2_ff & ~ior_d_ff & any_hit);
  assign host_out_irq  = out_irq_ff;
  assign host_in_irq   = in_irq_ff;

  // cpu side view
  assign cpu_in_data = in_buf_ff;
  assign cpu_status  = status_ff;
  assign cpu_in_irq  = status_ff[`KBCHM_ST_IN_FULL];               // see [RL18]

  // alternate pin functions
  assign a20_output_pin       = a20_port_bit;                      // see [RL15]
  assign a20_output_oe_n      = ~a20_pin_sel;                      // see [RL15]
  assign kb_reset_output_pin  = kb_reset_port_bit;                 // see [RL16]
  assign kb_reset_output_oe_n = ~kb_reset_pin_sel;                 // see [RL16]
  assign wdt_reset            = kb_reset_wdt_en & kb_reset_port_bit; // see [RL16]

endmodule // kbchm_host_port

// File: shared/kbchm_defs.vh
`ifndef KBCHM_DEFS_VH
`define KBCHM_DEFS_VH

// isa port addresses, ten address bits decoded
`define KBCHM_ADDR_DATA      10'h060
`define KBCHM_ADDR_CMD       10'h064
`define KBCHM_ADDR_CLK_IDX   10'h070
`define KBCHM_ADDR_CLK_DATA  10'h071
`define KBCHM_ADDR_ZERO      10'h000
`define KBCHM_SEC_DATA_OFS   10'h001

// status register layout
`define KBCHM_ST_OUT_FULL    0
`define KBCHM_ST_IN_FULL     1
`define KBCHM_ST_CD          3
`define KBCHM_ST_RESET       8'h00
`define KBCHM_ST_UD_MASK     8'hF4

// address bit that tells command from data
`define KBCHM_SA_CD          2

// clock ram geometry
`define KBCHM_RAM_AW         7
`define KBCHM_RAM_DEPTH      128
`define KBCHM_BANKS          2
`define KBCHM_IDX_RESET      8'h00

// second clock bank enable in mode register
`define KBCHM_MODE_BANK_EN   0

// data bus width
`define KBCHM_DW             8
`define KBCHM_BYTE_ZERO      8'h00

`endif

// File: verif/kbchm_host_port_props.sv
`timescale 1ns/1ps

// port checker for the host mailbox
module kbchm_host_port_props (
  input wire       mclk,
  input wire       rst,
  input wire       isa_aen,
  input wire       isa_iow_n,
  input wire       isa_data_oe_n,
  input wire       host_out_irq,
  input wire       host_in_irq,
  input wire       cpu_out_wr,
  input wire       cpu_in_rd,
  input wire [7:0] cpu_status,
  input wire       enable_flags,
  input wire       out_irq_port_bit,
  input wire       in_irq_port_bit,
  input wire       a20_port_bit,
  input wire       kb_reset_port_bit,
  input wire       a20_output_pin,
  input wire       kb_reset_output_pin
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // quiet stretches of the bus
  sequence s_no_write;
    isa_iow_n [*4];
  endsequence
  sequence s_dma;
    isa_aen [*4];
  endsequence

  a_out_full_set: assert property (cpu_out_wr |=> cpu_status[0])
    else $error("output full not set");
  a_in_full_clear: assert property ((s_no_write ##0 cpu_in_rd)
    |-> ##[1:2] !cpu_status[1]) else $error("input full not cleared");
  a_irq_reset: assert property ($fell(rst) |-> !host_out_irq)
    else $error("keyboard irq high after reset");
  a_out_irq_gated: assert property (enable_flags && $past(enable_flags)
    && out_irq_port_bit == $past(out_irq_port_bit)
    |-> host_out_irq == (out_irq_port_bit & cpu_status[0]))
    else $error("gated keyboard irq wrong");
  a_out_irq_ungated: assert property (!enable_flags && !$past(enable_flags)
    && !$past(rst) |-> host_out_irq == $past(out_irq_port_bit))
    else $error("ungated keyboard irq wrong");
  a_in_irq_gated: assert property (enable_flags && $past(enable_flags)
    && !$past(rst) && in_irq_port_bit == $past(in_irq_port_bit)
    |-> host_in_irq == (in_irq_port_bit & !cpu_status[1]))
    else $error("gated mouse irq wrong");
  a_in_irq_ungated: assert property (!enable_flags && !$past(enable_flags)
    && !$past(rst) |-> host_in_irq == $past(in_irq_port_bit))
    else $error("ungated mouse irq wrong");
  a_dma_quiet: assert property (s_dma |-> isa_data_oe_n)
    else $error("bus driven in dma cycle");
  a_gpio_route: assert property (a20_output_pin == a20_port_bit
    && kb_reset_output_pin == kb_reset_port_bit) else $error("port bit not on pin");
endmodule // kbchm_host_port_props

bind kbchm_host_port kbchm_host_port_props u_props (.*);

// File: verif/kbchm_host_port_test.sv
`timescale 1ns/1ps

module kbchm_host_port_test;
  reg        mclk, rst, cpu_out_wr, cpu_in_rd, cpu_status_wr, enable_flags;
  reg        out_irq_port_bit, in_irq_port_bit, a20_port_bit, kb_reset_port_bit;
  reg        a20_pin_sel, kb_reset_pin_sel, kb_reset_wdt_en;
  reg  [7:0] cpu_out_data, cpu_status_data, clock_mode, q;
  reg  [9:0] clock_sec_base;
  wire [9:0] isa_sa;
  wire [7:0] isa_data_in, isa_data_out, cpu_in_data, cpu_status;
  wire       isa_aen, isa_iow_n, isa_ior_n, isa_data_oe_n, host_out_irq, host_in_irq;
  wire       cpu_in_irq, a20_output_pin, a20_output_oe_n, kb_reset_output_pin;
  wire       kb_reset_output_oe_n, wdt_reset;
  integer    err_total, comparisons, i;

  kbchm_host_port DUT (.*);
  kbchm_isa_host host (.mclk(mclk), .isa_data_out(isa_data_out),
    .isa_data_oe_n(isa_data_oe_n), .isa_sa(isa_sa),
    .isa_aen(isa_aen), .isa_iow_n(isa_iow_n), .isa_ior_n(isa_ior_n), .isa_data_in(isa_data_in));

  // 50 mhz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // hang guard
  initial begin
    #200000;
    err_total = err_total + 1;
    test_done;
  end

  task tick; begin @(posedge mclk); #1; end endtask
  task wr(input [9:0] a, input [7:0] d); host.io(1'b1, a, d, 1'b0, q); endtask
  task rd(input [9:0] a); host.io(1'b0, a, 8'h00, 1'b0, q); endtask
  task cpu_read; begin tick; cpu_in_rd = 1'b1; tick; cpu_in_rd = 1'b0; tick; end endtask
  task cpu_push(input [7:0] d);
    begin
      tick;
      cpu_out_data = d;
      cpu_out_wr = 1'b1;
      tick;
      cpu_out_wr = 1'b0;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  // host to cpu bytes and command flag
  task t_host_in;
    begin
      chk(cpu_status, 8'h00);
      chk({7'h00, host_out_irq}, 8'h00);
      rd(10'h064);
      chk(q & 8'h02, 8'h00);
      wr(10'h060, 8'hA5);
      chk(cpu_status & 8'h0A, 8'h02);
      chk(cpu_in_data, 8'hA5);
      chk({7'h00, cpu_in_irq}, 8'h01);
      cpu_read;
      chk(cpu_status & 8'h02, 8'h00);
      chk({7'h00, cpu_in_irq}, 8'h00);
      wr(10'h064, 8'h3C);
      chk(cpu_in_data, 8'h3C);
      rd(10'h064);
      chk(q, 8'h0A);
      cpu_read;
      $display("t_host_in done");
    end
  endtask

  // cpu to host bytes and keyboard irq
  task t_host_out;
    begin
      enable_flags = 1'b1;
      out_irq_port_bit = 1'b1;
      cpu_push(8'h5A);
      chk({6'h00, cpu_status[0], host_out_irq}, 8'h03);
      rd(10'h060);
      chk(q, 8'h5A);
      chk({6'h00, cpu_status[0], host_out_irq}, 8'h00);
      out_irq_port_bit = 1'b0;
      cpu_push(8'hC3);
      chk({6'h00, cpu_status[0], host_out_irq}, 8'h02);
      rd(10'h060);
      chk(q, 8'hC3);
      $display("t_host_out done");
    end
  endtask

  // mouse irq gated, then both irqs ungated
  task t_irqs;
    begin
      in_irq_port_bit = 1'b1;
      cpu_read;
      chk({7'h00, host_in_irq}, 8'h01);
      wr(10'h060, 8'h11);
      chk({7'h00, host_in_irq}, 8'h00);
      cpu_read;
      chk({7'h00, host_in_irq}, 8'h01);
      enable_flags = 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        {in_irq_port_bit, out_irq_port_bit} = i[1:0];
        tick;
        tick;
        chk({6'h00, host_in_irq, host_out_irq}, i[7:0]);
      end
      $display("t_irqs done");
    end
  endtask

  // clock ram index, data and second bank
  task t_clock;
    begin
      wr(10'h070, 8'h05);
      wr(10'h071, 8'h77);
      wr(10'h070, 8'h06);
      wr(10'h071, 8'h88);
      clock_mode = 8'h01;
      clock_sec_base = 10'h170;
      wr(10'h170, 8'h05);
      wr(10'h171, 8'h99);
      wr(10'h070, 8'h06);
      rd(10'h071);
      chk(q, 8'h88);
      wr(10'h170, 8'h05);
      rd(10'h171);
      chk(q, 8'h99);
      wr(10'h070, 8'h05);
      rd(10'h071);
      chk(q, 8'h77);
      $display("t_clock done");
    end
  endtask

  // dma cycles, user status bits, pin routing
  task t_misc;
    begin
      host.io(1'b1, 10'h060, 8'hEE, 1'b1, q);
      chk({7'h00, cpu_status[1]}, 8'h00);
      host.io(1'b0, 10'h060, 8'h00, 1'b1, q);
      chk(q, 8'hFF);
      tick;
      cpu_status_data = 8'hFF;
      cpu_status_wr = 1'b1;
      tick;
      cpu_status_wr = 1'b0;
      rd(10'h064);
      chk(q, 8'hF4);
      rst = 1'b1;
      tick;
      chk(cpu_status, 8'h00);
      chk({6'h00, host_in_irq, host_out_irq}, 8'h00);
      rst = 1'b0;
      tick;
      for (i = 0; i < 16; i = i + 1) begin
        {kb_reset_pin_sel, a20_pin_sel, kb_reset_port_bit, a20_port_bit} = i[3:0];
        kb_reset_wdt_en = i[2];
        tick;
        chk({3'h0, a20_output_pin, a20_output_oe_n, kb_reset_output_pin, kb_reset_output_oe_n,
          wdt_reset}, {3'h0, i[0], ~i[2], i[1], ~i[3], i[2] & i[1]});
      end
      $display("t_misc done");
    end
  endtask

  // verdict and end of run
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask

  // reset, then scenarios
  initial begin
    err_total = 0;
    comparisons = 0;
    rst = 1'b1;
    {cpu_out_wr, cpu_in_rd, cpu_status_wr, enable_flags} = 4'h0;
    {out_irq_port_bit, in_irq_port_bit, a20_port_bit, kb_reset_port_bit} = 4'h0;
    {a20_pin_sel, kb_reset_pin_sel, kb_reset_wdt_en} = 3'h0;
    {cpu_out_data, cpu_status_data, clock_mode, q} = 32'h0000_0000;
    clock_sec_base = 10'h000;
    repeat (5) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_host_in;
    t_host_out;
    t_irqs;
    t_clock;
    t_misc;
    test_done;
  end
endmodule // kbchm_host_port_test

// File: verif/kbchm_isa_host.sv
`timescale 1ns/1ps

// isa host issuing one i/o cycle at a time
module kbchm_isa_host (
  input  wire       mclk,
  input  wire [7:0] isa_data_out,
  input  wire       isa_data_oe_n,
  output reg  [9:0] isa_sa,
  output reg        isa_aen,
  output reg        isa_iow_n,
  output reg        isa_ior_n,
  output reg  [7:0] isa_data_in
);
  // bus idle at time zero
  initial begin
    isa_sa = 10'h000;
    isa_aen = 1'b0;
    isa_iow_n = 1'b1;
    isa_ior_n = 1'b1;
    isa_data_in = 8'h00;
  end

  // strobe low six clocks, high six clocks
  task io(input wr, input [9:0] a, input [7:0] d, input dma, output [7:0] q);
    begin
      @(posedge mclk);
      #1;
      isa_sa = a;
      isa_aen = dma;
      isa_data_in = d;
      isa_iow_n = !wr;
      isa_ior_n = wr;
      repeat (6) @(posedge mclk);
      #1;
      q = isa_data_oe_n ? 8'hFF : isa_data_out;  // pulled up when undriven
      isa_iow_n = 1'b1;
      isa_ior_n = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      isa_data_in = ~d;  // driven inverted, no stale byte
      repeat (4) @(posedge mclk);
      #1;
    end
  endtask
endmodule // kbchm_isa_host
